// file: hw/cam_matrix.sv
`timescale 1ns/1ps

// Overview of operation
// - Each of the four channels turns on from an input pin or from its channel_on_bit.
// - Assigned drive mapping is used only while assigned_drive_select is set.
// - After every reset the block comes up in direct drive mode.
// - With pin_register_combine at 0 a channel is on if its bit or its mapped pin is on.
// - With pin_register_combine at 1 a channel is on only while its bit and its pin are high.
// - In direct drive the pins act in normal operation, stand-by and limp home alike.
// - In direct drive channel 0 never follows a pin; it follows its channel_on_bit with pin_register_combine at 0 and stays off at 1.
// - Direct drive maps pin one to channel 1, pin two to channel 2, pin three to channel 3.
// - Assigned drive maps pin one to channel 0, pin two to channel 1, pin three to 2 and 3.
// - Channels 2 and 3 each have a register-selected bulb or LED mode.
// - Under inverse current a channel keeps its state and sets no error flag.
// - An unconnected input pin is taken as low and never turns a channel on.
// - During a reset the assigned mapping is ignored; only channels 1 to 3 follow pins.
// - A reset turns off register-driven channels; pins keep driving channels only through the direct mapping.
module cam_matrix
  import cam_pkg::*;
(
  input wire logic sysClk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic inputPinOne,
  input wire logic inputPinTwo,
  input wire logic inputPinThree,
  input wire logic limpHomeInput,
  input wire logic [3:0] inverseCurrent,
  input wire logic [3:0] faultDetect,
  output logic [3:0] channelOn,
  output logic [1:0] ledModeSel,
  output logic irq
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pinSync;
  logic limpSync;
  logic [3:0] invSync;
  logic [3:0] faultSync;

  // Pins, limp home, inverse current and fault sense are all asynchronous
  cam_sync2 #(
    .WIDTH(12)
  ) u_sync (
    .sysClk(sysClk),
    .resetn(resetn),
    .asyncIn({faultDetect, inverseCurrent, limpHomeInput, inputPinThree, inputPinTwo,
      inputPinOne}),
    .syncOut({faultSync, invSync, limpSync, pinSync})
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0] channelOnReg;
  logic assignedSel;
  logic combineSel;
  logic [7:0] irqStatus;
  logic [7:0] irqMask;
  logic [7:0] irqSet;
  logic [7:0] irqClear;
  logic resetCmd;
  logic resetActive;
  logic writeAllowed;
  logic [3:0] pinCh;
  logic [3:0] next_channelOn;

  // Limp home keeps the write registers at default and blocks writes
  assign writeAllowed = regWrite && !limpSync;
  assign resetCmd = writeAllowed && (regAddr == CAM_OFS_RESET_CMD) &&
    regWdata[CAM_BIT_RESET_CMD];
  assign resetActive = resetCmd || limpSync;

  always_ff @(posedge sysClk or negedge resetn) begin
    if (!resetn) begin
      channelOnReg <= CAM_RST_CHANNEL_ON;
    end else if (resetActive) begin
      channelOnReg <= CAM_RST_CHANNEL_ON;
    end else if (writeAllowed && regAddr == CAM_OFS_CHANNEL_ON) begin
      channelOnReg <= regWdata[3:0];
    end
  end

  always_ff @(posedge sysClk or negedge resetn) begin
    if (!resetn) begin
      {combineSel, assignedSel} <= CAM_RST_INPUT_CONFIG;
    end else if (resetActive) begin
      {combineSel, assignedSel} <= CAM_RST_INPUT_CONFIG;
    end else if (writeAllowed && regAddr == CAM_OFS_INPUT_CONFIG) begin
      assignedSel <= regWdata[CAM_BIT_ASSIGNED];
      combineSel <= regWdata[CAM_BIT_COMBINE];
    end
  end

  // Bit 0 selects LED mode for channel 2, bit 1 for channel 3
  always_ff @(posedge sysClk or negedge resetn) begin
    if (!resetn) begin
      ledModeSel <= CAM_RST_LED_MODE;
    end else if (resetActive) begin
      ledModeSel <= CAM_RST_LED_MODE;
    end else if (writeAllowed && regAddr == CAM_OFS_LED_MODE) begin
      ledModeSel <= regWdata[1:0];
    end
  end

  always_ff @(posedge sysClk or negedge resetn) begin
    if (!resetn) begin
      irqMask <= CAM_RST_IRQ_MASK;
    end else if (resetActive) begin
      irqMask <= CAM_RST_IRQ_MASK;
    end else if (writeAllowed && regAddr == CAM_OFS_IRQ_MASK) begin
      irqMask <= regWdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Input switch matrix
  // ----------------------------------------------------------------
  always_comb begin
    if (assignedSel && !resetActive) begin
      pinCh = {pinSync[2], pinSync[2], pinSync[1], pinSync[0]};
    end else begin
      // Channel 0 has no pin here; also the only map used during a reset
      pinCh = {pinSync[2], pinSync[1], pinSync[0], 1'b0};
    end
  end

  // Register bits count as cleared in the very cycle a reset hits, so
  // only pin-driven channels survive it
  genvar gc;
  generate
    for (gc = 0; gc < CAM_CHANNELS; gc++) begin : gen_chan
      logic regBit;
      assign regBit = channelOnReg[gc] && !resetActive;
      always_comb begin
        if (invSync[gc]) begin
          next_channelOn[gc] = channelOn[gc];
        end else if (combineSel) begin
          next_channelOn[gc] = regBit && pinCh[gc];
        end else begin
          next_channelOn[gc] = regBit || pinCh[gc];
        end
      end
    end
  endgenerate

  always_ff @(posedge sysClk or negedge resetn) begin
    if (!resetn) begin
      channelOn <= CAM_RST_CHANNEL_ON;
    end else begin
      channelOn <= next_channelOn;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // Error events are suppressed while inverse current flows; a set in
  // the same cycle as a write-one clear wins
  assign irqSet = {faultSync & ~invSync, next_channelOn ^ channelOn};
  assign irqClear = (writeAllowed && regAddr == CAM_OFS_IRQ_STATUS) ? regWdata[7:0] : 8'h00;

  always_ff @(posedge sysClk or negedge resetn) begin
    if (!resetn) begin
      irqStatus <= 8'h00;
    end else if (resetActive) begin
      irqStatus <= {4'h0, irqSet[3:0]};
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqSet;
    end
  end

  always_ff @(posedge sysClk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge sysClk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= CAM_READ_ZERO;
    end else if (regRead) begin
      case (regAddr)
        CAM_OFS_CHANNEL_ON: begin
          regRdata <= {28'h000_0000, channelOnReg};
        end
        CAM_OFS_INPUT_CONFIG: begin
          regRdata <= {30'h0000_0000, combineSel, assignedSel};
        end
        CAM_OFS_LED_MODE: begin
          regRdata <= {30'h0000_0000, ledModeSel};
        end
        CAM_OFS_STATE: begin
          regRdata <= {20'h0_0000, invSync, limpSync, pinSync, channelOn};
        end
        CAM_OFS_IRQ_STATUS: begin
          regRdata <= {24'h00_0000, irqStatus};
        end
        CAM_OFS_IRQ_MASK: begin
          regRdata <= {24'h00_0000, irqMask};
        end
        default: begin
          regRdata <= CAM_READ_ZERO;
        end
      endcase
    end else begin
      regRdata <= CAM_READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sysClk);
  endclocking
  default disable iff (!resetn);

  // Counts the first edges after reset so $past never looks back into it
  logic [1:0] startCount;
  always_ff @(posedge sysClk or negedge resetn) begin
    if (!resetn) begin
      startCount <= 2'h0;
    end else if (startCount != 2'h3) begin
      startCount <= startCount + 2'h1;
    end
  end

  a_or_combine: assert property (
    (!combineSel && !resetActive && !invSync[1] && channelOnReg[1] && !pinSync[0])
      |=> channelOn[1])
    else $error("register bit alone failed to turn channel 1 on");

  a_or_off: assert property (
    (!combineSel && !channelOnReg[1] && !pinCh[1] && !invSync[1]) |=> !channelOn[1])
    else $error("channel 1 on with neither its bit nor its pin");

  a_and_combine: assert property (
    (combineSel && !assignedSel && !pinSync[0] && !invSync[1]) |=> !channelOn[1])
    else $error("channel 1 on without its pin in gated mode");

  a_and_gate_on: assert property (
    (combineSel && !assignedSel && !resetActive && pinSync[1] && channelOnReg[2]
      && !invSync[2]) |=> channelOn[2])
    else $error("gated channel 2 stayed off with bit and pin high");

  a_chan0_direct: assert property (
    (!assignedSel && !channelOnReg[0] && !invSync[0]) |=> !channelOn[0])
    else $error("channel 0 on from a pin in direct drive");

  a_direct_map: assert property (
    (!assignedSel && !combineSel && pinSync[1] && !invSync[2]) |=> channelOn[2])
    else $error("pin two did not drive channel 2");

  a_direct_one: assert property (
    (!assignedSel && !combineSel && pinSync[0] && !invSync[1]) |=> channelOn[1])
    else $error("pin one did not drive channel 1");

  a_direct_three: assert property (
    (!assignedSel && !combineSel && pinSync[2] && !invSync[3]) |=> channelOn[3])
    else $error("pin three did not drive channel 3");

  a_assigned_map: assert property (
    (assignedSel && !resetActive && !combineSel && pinSync[2] && pinSync[0]
      && invSync == 4'h0) |=> (channelOn[3:2] == 2'b11) && channelOn[0])
    else $error("assigned mapping wrong for pins one and three");

  a_assigned_two: assert property (
    (assignedSel && !resetActive && !combineSel && pinSync[1] && !invSync[1])
      |=> channelOn[1])
    else $error("pin two did not drive channel 1 in assigned drive");

  a_assign_write: assert property (
    (writeAllowed && regAddr == CAM_OFS_INPUT_CONFIG) |=>
      assignedSel == $past(regWdata[CAM_BIT_ASSIGNED]))
    else $error("assigned drive select not taken");

  a_inverse_hold: assert property (
    invSync[1] |=> $stable(channelOn[1]))
    else $error("channel changed under inverse current");

  a_no_err_inverse: assert property (
    (invSync[2] && !irqStatus[CAM_POS_IRQ_ERROR + 2]) |=>
      !irqStatus[CAM_POS_IRQ_ERROR + 2])
    else $error("error flag set under inverse current");

  a_err_on_fault: assert property (
    (faultSync[1] && !invSync[1] && !resetActive) |=> irqStatus[CAM_POS_IRQ_ERROR + 1])
    else $error("fault without inverse current set no error flag");

  a_reset_clears: assert property (
    resetActive |=> (channelOnReg == 4'h0) && !assignedSel && !combineSel)
    else $error("reset left registers set");

  a_reset_pins: assert property (
    (resetActive && pinSync[0] && !invSync[1] && !combineSel) |=> channelOn[1])
    else $error("pin-driven channel 1 dropped during reset");

  a_reset_no_assign: assert property (
    (resetActive && assignedSel && pinSync[2] && !pinSync[1] && !invSync[2])
      |=> !channelOn[2])
    else $error("assigned mapping used during a reset");

  a_reset_chan0: assert property (
    (resetActive && !invSync[0]) |=> !channelOn[0])
    else $error("register-driven channel 0 survived reset");

  a_led_select: assert property (
    (writeAllowed && !resetCmd && regAddr == CAM_OFS_LED_MODE) |=>
      ledModeSel == $past(regWdata[1:0]))
    else $error("LED mode select not taken");

  a_led_hold: assert property (
    (!resetActive && !(writeAllowed && regAddr == CAM_OFS_LED_MODE))
      |=> $stable(ledModeSel))
    else $error("LED mode select changed without a write");

  a_sync_depth: assert property (
    (startCount == 2'h3) |-> pinSync == $past(
      {inputPinThree, inputPinTwo, inputPinOne}, 2))
    else $error("pin synchroniser depth wrong");

  a_sync_limp: assert property (
    (startCount == 2'h3) |-> limpSync == $past(limpHomeInput, 2))
    else $error("limp home synchroniser depth wrong");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_gated_pwm: cover property (
    combineSel && channelOnReg[1] && pinSync[0] ##1 channelOn[1] ##1 !channelOn[1]);
  c_assigned_pair: cover property (assignedSel && channelOn[3:2] == 2'b11);
  c_reset_pin_hold: cover property (resetActive && channelOn[2] ##1 channelOn[2]);
  c_inverse_freeze: cover property ((invSync[3] && channelOn[3]) [*3]);

endmodule

// file: hw/cam_pkg.sv
package cam_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] CAM_OFS_CHANNEL_ON = 8'h00;
  localparam logic [7:0] CAM_OFS_INPUT_CONFIG = 8'h04;
  localparam logic [7:0] CAM_OFS_LED_MODE = 8'h08;
  localparam logic [7:0] CAM_OFS_STATE = 8'h0C;
  localparam logic [7:0] CAM_OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] CAM_OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] CAM_OFS_RESET_CMD = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CAM_CHANNELS = 4;
  localparam int CAM_PINS = 3;
  localparam int CAM_BIT_ASSIGNED = 0;
  localparam int CAM_BIT_COMBINE = 1;
  localparam int CAM_BIT_RESET_CMD = 0;
  // State register: channel outputs, synchronised pins, limp home, inverse current
  localparam int CAM_POS_STATE_CHAN = 0;
  localparam int CAM_POS_STATE_PIN = 4;
  localparam int CAM_POS_STATE_LIMP = 7;
  localparam int CAM_POS_STATE_INV = 8;
  // Interrupt status: channel change events, then error events
  localparam int CAM_POS_IRQ_CHANGE = 0;
  localparam int CAM_POS_IRQ_ERROR = 4;
  localparam int CAM_IRQ_BITS = 8;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0] CAM_RST_CHANNEL_ON = 4'h0;
  localparam logic [1:0] CAM_RST_INPUT_CONFIG = 2'h0;
  localparam logic [1:0] CAM_RST_LED_MODE = 2'h0;
  localparam logic [7:0] CAM_RST_IRQ_MASK = 8'h00;
  localparam logic [31:0] CAM_READ_ZERO = 32'h0000_0000;

endpackage

// file: hw/cam_sync2.sv
`timescale 1ns/1ps

module cam_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic sysClk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageOne;

  // ----------------------------------------------------------------
  // Two-flop synchroniser, one chain per bit
  // ----------------------------------------------------------------
  // Reset value low: a pin is only trusted once it has been seen high
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : gen_bit
      always_ff @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
          stageOne[gi] <= 1'b0;
          syncOut[gi] <= 1'b0;
        end else begin
          stageOne[gi] <= asyncIn[gi];
          syncOut[gi] <= stageOne[gi];
        end
      end
    end
  endgenerate

endmodule

// file: tb/cam_host_model.sv
`timescale 1ns/1ps

module cam_host_model #(
  parameter time SKEW = 1ns
) (
  input wire logic [2:0] pinCmd,
  input wire logic [2:0] pinFloat,
  output logic inputPinOne,
  output logic inputPinTwo,
  output logic inputPinThree
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Host pins move off the device clock; a floating pin settles low via the pull-down
  assign #SKEW {inputPinThree, inputPinTwo, inputPinOne} = pinCmd & ~pinFloat;
endmodule

// file: tb/channel_activation_matrix_bench.sv
`timescale 1ns/1ps

module channel_activation_matrix_bench;
  import cam_pkg::*;
  typedef struct packed {
    logic [1:0] cfg;
    logic [3:0] chanReg;
    logic [2:0] pin;
    logic [3:0] expOn;
  } cam_row_s;
  logic sysClk, resetn, regWrite, regRead, limpHomeInput;
  logic inputPinOne, inputPinTwo, inputPinThree, irq;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic [2:0] pinCmd, pinFloat;
  logic [3:0] inverseCurrent, channelOn, faultDetect;
  logic [1:0] ledModeSel;
  int n_mismatch = 0;
  int checked = 0;
  cam_row_s rows [8];

  cam_host_model i_cam_host_model (.pinCmd(pinCmd), .pinFloat(pinFloat),
    .inputPinOne(inputPinOne), .inputPinTwo(inputPinTwo), .inputPinThree(inputPinThree));
  cam_matrix i_cam_matrix (.sysClk(sysClk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .inputPinOne(inputPinOne), .inputPinTwo(inputPinTwo), .inputPinThree(inputPinThree),
    .limpHomeInput(limpHomeInput), .inverseCurrent(inverseCurrent), .faultDetect(faultDetect),
    .channelOn(channelOn), .ledModeSel(ledModeSel), .irq(irq));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sysClk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge sysClk);
    regWrite <= 1'b0;
  endtask

  // Read data stand only in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sysClk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sysClk);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask

  // Longer than the three-edge pin path, so every change has landed
  task automatic settle();
    repeat (4) @(posedge sysClk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] expv, input string what);
    checked++;
    if (got !== expv) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, expv);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    sysClk = 1'b0;
  end
  always #2.5 sysClk = ~sysClk;

  initial begin
    #100us;
    n_mismatch++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {regWrite, regRead, limpHomeInput} = 3'h0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    pinCmd = 3'h0;
    pinFloat = 3'h0;
    inverseCurrent = 4'h0;
    faultDetect = 4'h0;
    rows[0] = {2'h0, 4'h0, 3'h7, 4'he};
    rows[1] = {2'h0, 4'h1, 3'h0, 4'h1};
    rows[2] = {2'h2, 4'he, 3'h5, 4'ha};
    rows[3] = {2'h1, 4'h0, 3'h1, 4'h1};
    rows[4] = {2'h1, 4'h0, 3'h4, 4'hc};
    rows[5] = {2'h1, 4'h4, 3'h2, 4'h6};
    rows[6] = {2'h3, 4'hf, 3'h5, 4'hd};
    rows[7] = {2'h3, 4'h5, 3'h7, 4'h5};
    repeat (20) @(posedge sysClk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      rd(CAM_OFS_CHANNEL_ON + 8'(4 * i), d);
      chk(d, CAM_READ_ZERO, "value after reset");
    end
    $display("reset values done");
    foreach (rows[i]) begin
      wr(CAM_OFS_INPUT_CONFIG, 32'(rows[i].cfg));
      wr(CAM_OFS_CHANNEL_ON, 32'(rows[i].chanReg));
      pinCmd <= rows[i].pin;
      settle();
      chk(32'(channelOn), 32'(rows[i].expOn), "matrix row");
    end
    $display("matrix table done");
    wr(CAM_OFS_INPUT_CONFIG, 32'h0000_0000);
    wr(CAM_OFS_CHANNEL_ON, 32'h0000_0000);
    pinCmd <= 3'h0;
    settle();
    @(posedge sysClk);
    pinCmd <= 3'h2;
    repeat (2) @(posedge sysClk);
    #1 chk(32'(channelOn), 32'h0000_0000, "pin seen too early");
    @(posedge sysClk);
    #1 chk(32'(channelOn), 32'h0000_0004, "pin seen late");
    pinCmd <= 3'h7;
    pinFloat <= 3'h7;
    settle();
    chk(32'(channelOn), 32'h0000_0000, "floating pins");
    pinFloat <= 3'h0;
    pinCmd <= 3'h0;
    wr(CAM_OFS_INPUT_CONFIG, 32'h0000_0002);
    wr(CAM_OFS_CHANNEL_ON, 32'h0000_0002);
    repeat (2) begin
      pinCmd <= 3'h1;
      settle();
      chk(32'(channelOn), 32'h0000_0002, "pwm high passes");
      pinCmd <= 3'h0;
      settle();
      chk(32'(channelOn), 32'h0000_0000, "pwm low blocks");
    end
    wr(CAM_OFS_CHANNEL_ON, 32'h0000_0000);
    wr(CAM_OFS_INPUT_CONFIG, 32'h0000_0000);
    wr(CAM_OFS_LED_MODE, 32'h0000_0003);
    settle();
    chk(32'(ledModeSel), 32'h0000_0003, "led mode");
    $display("pin and led tests done");
    wr(CAM_OFS_IRQ_MASK, 32'h0000_0000);
    wr(CAM_OFS_IRQ_STATUS, 32'h0000_00ff);
    wr(CAM_OFS_CHANNEL_ON, 32'h0000_0001);
    settle();
    rd(CAM_OFS_IRQ_STATUS, d);
    chk(d, 32'h0000_0001, "change event");
    chk(32'(irq), 32'h0000_0000, "masked irq");
    wr(CAM_OFS_IRQ_MASK, 32'h0000_0001);
    settle();
    chk(32'(irq), 32'h0000_0001, "unmasked irq");
    wr(CAM_OFS_IRQ_STATUS, 32'h0000_0001);
    settle();
    chk(32'(irq), 32'h0000_0000, "cleared irq");
    $display("interrupt test done");
    wr(CAM_OFS_CHANNEL_ON, 32'h0000_0002);
    settle();
    inverseCurrent <= 4'h2;
    faultDetect <= 4'h2;
    wr(CAM_OFS_CHANNEL_ON, 32'h0000_0000);
    settle();
    chk(32'(channelOn), 32'h0000_0002, "frozen channel");
    rd(CAM_OFS_IRQ_STATUS, d);
    chk(32'(d[7:4]), 32'h0000_0000, "error flag under inverse current");
    inverseCurrent <= 4'h0;
    settle();
    chk(32'(channelOn), 32'h0000_0000, "released channel");
    rd(CAM_OFS_IRQ_STATUS, d);
    chk(32'(d[7:4]), 32'h0000_0002, "error flag after inverse current");
    faultDetect <= 4'h0;
    wr(CAM_OFS_INPUT_CONFIG, 32'h0000_0001);
    wr(CAM_OFS_CHANNEL_ON, 32'h0000_0001);
    pinCmd <= 3'h4;
    settle();
    chk(32'(channelOn), 32'h0000_000d, "before soft reset");
    wr(CAM_OFS_RESET_CMD, 32'h0000_0001);
    settle();
    chk(32'(channelOn), 32'h0000_0008, "after soft reset");
    rd(CAM_OFS_INPUT_CONFIG, d);
    chk(d, CAM_READ_ZERO, "config after soft reset");
    wr(CAM_OFS_CHANNEL_ON, 32'h0000_0001);
    pinCmd <= 3'h1;
    settle();
    limpHomeInput <= 1'b1;
    settle();
    chk(32'(channelOn), 32'h0000_0002, "limp home");
    wr(CAM_OFS_CHANNEL_ON, 32'h0000_0001);
    settle();
    chk(32'(channelOn), 32'h0000_0002, "write in limp home");
    limpHomeInput <= 1'b0;
    settle();
    chk(32'(channelOn), 32'h0000_0002, "after limp home");
    $display("reset and limp home tests done");
    finish_test();
  end
endmodule
